// ---- logic/pst_pkg.sv ----
// Package of constants for the power-up self-test sequencer
// Functional notes
// R1: Power-up and the reset-power-on command run the same full self-test.
// R2: Faults flash error with power on; hardware adds talk and request, invalid ROM nothing, lower sum request, upper sum listen.
// R3: Flashing faults light talk for NV-RAM, talk and listen for DRAM, all three for interprocessor.
// R4: Any other lamp pattern is an internal, non-serviceable error.
// R5: Error lit steadily alone is a configuration error from NV-RAM setup.
// R6: The query-error-status command returns the recorded error.
// R7: With no fault only power stays lit and initialization begins.
// R8: An NV-RAM flag picks factory defaults or the user configuration.
// R9: Configuration registers are then loaded from NV-RAM.
// R10: Alarms are enabled only when their stored flag is set.
// R11: Channel registers load, then the scan sequencer is programmed.
// R12: Resetting the computation processor is the last step.
// R13: The sequence takes about five seconds, then ready is shown.
// R14: The expansion scan lamp is lit while an expansion scan is stored.
// R15: The expansion error lamp is lit exactly while an error exists.
// R16: Steps run strictly in order, each after the previous completes.
// R17: Error flashes at a fixed parameter rate; fault patterns hold until reset.
package pst_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned SELFTEST_MS    = 5000;
    localparam longint unsigned SELFTEST_CYC = 64'(SELFTEST_MS) * 64'(CLK_MHZ) * 64'd1000;
    localparam int unsigned FLASH_MS       = 250;
    localparam longint unsigned FLASH_CYC  = 64'(FLASH_MS) * 64'(CLK_MHZ) * 64'd1000;

    // ----------------------------------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STAT_OFS   = 12'h004;
    localparam logic [11:0] FAULT_OFS  = 12'h008;
    localparam logic [11:0] NVCFG_OFS  = 12'h00c;
    localparam logic [11:0] IRQST_OFS  = 12'h010;
    localparam logic [11:0] IRQMSK_OFS = 12'h014;
    localparam logic [11:0] ERRQ_OFS   = 12'h018;

    // CTRL bits (write-one actions)
    localparam int unsigned CTRL_RESTART  = 0;
    localparam int unsigned CTRL_CFGERR   = 1;
    localparam int unsigned CTRL_CFGCLR   = 2;
    // NVCFG bits
    localparam int unsigned NV_USERCFG    = 0;
    localparam int unsigned NV_ALARMON    = 1;
    // IRQ bits
    localparam int unsigned IRQ_DONE      = 0;
    localparam int unsigned IRQ_FAULT     = 1;
    localparam int unsigned IRQ_CFGERR    = 2;
    localparam int unsigned IRQ_W         = 3;

    // Fault codes
    localparam logic [2:0] FLT_NONE  = 3'h0;
    localparam logic [2:0] FLT_HW    = 3'h1;
    localparam logic [2:0] FLT_ROMV  = 3'h2;
    localparam logic [2:0] FLT_ROML  = 3'h3;
    localparam logic [2:0] FLT_ROMU  = 3'h4;
    localparam logic [2:0] FLT_NVRAM = 3'h5;
    localparam logic [2:0] FLT_DRAM  = 3'h6;
    localparam logic [2:0] FLT_IPC   = 3'h7;

    // Sequencer states
    typedef enum logic [3:0] {
        PST_IDLE, PST_CHECK, PST_FAULT, PST_SELECT, PST_REGLD,
        PST_ALARM, PST_CHLD, PST_SEQLD, PST_CPURST, PST_WAIT, PST_READY
    } pst_state_t;

endpackage : pst_pkg

// ---- logic/pst_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pst_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,     // System clock
    input  wire logic         presetn,  // Async reset, active low
    input  wire logic [W-1:0] async_in, // Pin level
    output logic      [W-1:0] sync_out  // Filtered level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // No reset on the stages: pins settle while reset is held
    always_ff @(posedge pclk) begin
        s1 <= async_in;
        s2 <= s1;
        s3 <= s2;
    end

    // Change accepted only once stages two and three agree, per bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    sync_out[i] <= s3[i];
                end
            end
        end
    end
endmodule : pst_sync
`default_nettype wire

// ---- logic/pst_top.sv ----
// Power-up self-test sequencer with front-panel lamp encoding
`timescale 1ns/1ps
`default_nettype none
module pst_top
    import pst_pkg::*;
#(
    parameter longint unsigned SELFTEST_CYCLES = SELFTEST_CYC, // Total sequence time
    parameter longint unsigned FLASH_CYCLES    = FLASH_CYC     // Half period of flashing
) (
    input  wire logic        pclk,                      // System clock, 200 MHz
    input  wire logic        presetn,                   // Async reset, active low
    input  wire logic        psel,                      // APB select
    input  wire logic        penable,                   // APB enable
    input  wire logic        pwrite,                    // APB direction
    input  wire logic [11:0] paddr,                     // APB byte address
    input  wire logic [31:0] pwdata,                    // APB write data
    output logic      [31:0] prdata,                    // APB read data
    output logic             pready,                    // APB ready
    output logic             pslverr,                   // APB error
    input  wire logic        reset_cmd,                 // Reset-power-on command pulse, same clock
    input  wire logic [2:0]  fault_code,                // Hardware test result pins
    input  wire logic        exp_scan_store,            // Expansion scan being buffered (pin)
    output logic             talk_led,                  // Talk lamp
    output logic             listen_led,                // Listen lamp
    output logic             service_request_indicator, // Service request lamp
    output logic             error_led,                 // Error lamp
    output logic             power_led,                 // Power lamp
    output logic             exp_scan_led,              // Expansion scan lamp
    output logic             exp_error_led,             // Expansion error lamp
    output logic             cfg_user_sel,              // User configuration selected
    output logic             cfg_load,                  // Load configuration registers
    output logic             alarm_enable,              // Alarms enabled
    output logic             chan_load,                 // Load channel configuration
    output logic             seq_load,                  // Program scan sequencer
    output logic             cpu_reset,                 // Computation processor reset pulse
    output logic             ready,                     // Ready for normal operation
    output logic             irq                        // Interrupt, level
);
    if (SELFTEST_CYCLES < 64'd16 || FLASH_CYCLES < 64'd1) begin : g_bad_counts
        $error("pst_top: counts too small");
    end

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [3:0] pins_s;
    pst_sync #(.W(4)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({exp_scan_store, fault_code}),
        .sync_out (pins_s)
    );
    logic [2:0] fault_s;
    logic       scan_s;
    assign fault_s = pins_s[2:0];
    assign scan_s  = pins_s[3];

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic hit;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign hit = (paddr <= ERRQ_OFS) && (paddr[1:0] == 2'h0);

    logic restart_req;
    logic cfg_err_set;
    logic cfg_err_clr;
    assign restart_req = reset_cmd || (wr_acc && paddr == CTRL_OFS && pwdata[CTRL_RESTART]); // R1
    assign cfg_err_set = wr_acc && paddr == CTRL_OFS && pwdata[CTRL_CFGERR];
    assign cfg_err_clr = wr_acc && paddr == CTRL_OFS && pwdata[CTRL_CFGCLR];

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    pst_state_t      state;
    pst_state_t      next_state;
    logic [63:0]     elapsed;
    logic [2:0]      fault_rec;
    logic [1:0]      nv_cfg;
    logic            cfg_err;

    // Steps advance one per cycle up to PST_WAIT, which holds for the count; fault halts here
    always_comb begin
        next_state = state;
        case (state)
            PST_IDLE:   next_state = PST_CHECK;
            PST_CHECK:  next_state = (fault_s != FLT_NONE) ? PST_FAULT : PST_SELECT; // R16
            PST_FAULT:  next_state = PST_FAULT;     // R17
            PST_SELECT: next_state = PST_REGLD;     // R16
            PST_REGLD:  next_state = PST_ALARM;     // R16
            PST_ALARM:  next_state = PST_CHLD;      // R16
            PST_CHLD:   next_state = PST_SEQLD;     // R16
            PST_SEQLD:  next_state = PST_CPURST;    // R16
            PST_CPURST: next_state = PST_WAIT;
            PST_WAIT:   next_state = (elapsed >= SELFTEST_CYCLES - 64'd1) ? PST_READY : PST_WAIT;
            PST_READY:  next_state = PST_READY;
            default:    next_state = PST_IDLE;
        endcase
    end

    // Restart from the same initial state for power-up and command alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PST_IDLE;
        end else if (restart_req) begin
            state <= PST_IDLE; // R1
        end else begin
            state <= next_state;
        end
    end

    // Elapsed-time counter paces the end of the sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed <= 64'd0;
        end else if (restart_req) begin
            elapsed <= 64'd0;
        end else if (state != PST_READY && state != PST_FAULT) begin
            elapsed <= elapsed + 64'd1; // R13
        end
    end

    // Fault is latched at the check step and kept until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_rec <= FLT_NONE;
        end else if (restart_req) begin
            fault_rec <= FLT_NONE;
        end else if (state == PST_CHECK) begin
            fault_rec <= fault_s; // R17
        end
    end

    // Configuration error flag; a set in the same cycle beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_err <= 1'b0;
        end else if (cfg_err_set) begin
            cfg_err <= 1'b1;
        end else if (cfg_err_clr || restart_req) begin
            cfg_err <= 1'b0;
        end
    end

    // NV-RAM image of the power-up flags, written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_cfg <= 2'h0;
        end else if (wr_acc && paddr == NVCFG_OFS) begin
            nv_cfg <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Initialization step outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_user_sel <= 1'b0;
            alarm_enable <= 1'b0;
        end else if (restart_req) begin
            cfg_user_sel <= 1'b0;
            alarm_enable <= 1'b0;
        end else begin
            if (state == PST_SELECT) begin
                cfg_user_sel <= nv_cfg[NV_USERCFG]; // R8
            end
            if (state == PST_ALARM) begin
                alarm_enable <= nv_cfg[NV_ALARMON]; // R10
            end
        end
    end

    // One-cycle strobes for each load step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_load  <= 1'b0;
            chan_load <= 1'b0;
            seq_load  <= 1'b0;
            cpu_reset <= 1'b0;
        end else begin
            cfg_load  <= !restart_req && state == PST_REGLD;  // R9
            chan_load <= !restart_req && state == PST_CHLD;   // R11
            seq_load  <= !restart_req && state == PST_SEQLD;  // R11
            cpu_reset <= !restart_req && state == PST_CPURST; // R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready <= 1'b0;
        end else begin
            ready <= !restart_req && next_state == PST_READY; // R13
        end
    end

    // ----------------------------------------------------------------
    // Lamp flashing and encoding
    // ----------------------------------------------------------------
    logic [63:0] flash_cnt;
    logic        flash;

    // Free toggle; shared by all fault patterns so the rate is fixed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt <= 64'd0;
            flash     <= 1'b0;
        end else if (flash_cnt >= FLASH_CYCLES - 64'd1) begin
            flash_cnt <= 64'd0;
            flash     <= !flash; // R17
        end else begin
            flash_cnt <= flash_cnt + 64'd1;
        end
    end

    logic next_talk;
    logic next_listen;
    logic next_srq;
    logic next_err;

    // Pattern table; unknown patterns never arise from legal codes
    always_comb begin
        next_talk   = 1'b0;
        next_listen = 1'b0;
        next_srq    = 1'b0;
        next_err    = 1'b0;
        if (state == PST_FAULT) begin
            next_err = flash; // R2
            case (fault_rec)
                FLT_HW:    begin next_talk = 1'b1; next_srq = 1'b1; end      // R2
                FLT_ROMV:  begin next_talk = 1'b0; end                       // R2
                FLT_ROML:  begin next_srq = 1'b1; end                        // R2
                FLT_ROMU:  begin next_listen = 1'b1; end                     // R2
                FLT_NVRAM: begin next_talk = 1'b1; end                       // R3
                FLT_DRAM:  begin next_talk = 1'b1; next_listen = 1'b1; end   // R3
                FLT_IPC:   begin                                             // R3
                    next_talk = 1'b1;
                    next_listen = 1'b1;
                    next_srq = 1'b1;
                end
                default:   begin next_talk = 1'b1; next_listen = 1'b1; next_err = 1'b1; end // R4
            endcase
        end else if (cfg_err) begin
            next_err = 1'b1; // R5
        end
        // Otherwise all off: no fault leaves only power lit (R7)
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            talk_led                  <= 1'b0;
            listen_led                <= 1'b0;
            service_request_indicator <= 1'b0;
            error_led                 <= 1'b0;
            power_led                 <= 1'b0;
        end else begin
            talk_led                  <= next_talk;
            listen_led                <= next_listen;
            service_request_indicator <= next_srq;
            error_led                 <= next_err;
            power_led                 <= 1'b1; // R7
        end
    end

    // Expansion chassis lamps follow scan storage and any error condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_scan_led  <= 1'b0;
            exp_error_led <= 1'b0;
        end else begin
            exp_scan_led  <= scan_s;                          // R14
            exp_error_led <= cfg_err || (state == PST_FAULT); // R15
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: sticky, write-one-to-clear, set wins
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;
    assign irq_ev[IRQ_DONE]   = !restart_req && next_state == PST_READY && state != PST_READY;
    assign irq_ev[IRQ_FAULT]  = !restart_req && next_state == PST_FAULT && state != PST_FAULT;
    assign irq_ev[IRQ_CFGERR] = cfg_err_set && !cfg_err;
    assign irq_clr = (wr_acc && paddr == IRQST_OFS) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st <= '0;
        end else begin
            irq_st <= (irq_st & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_acc && paddr == IRQMSK_OFS) begin
            irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_st & ~irq_clr) | irq_ev) & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // APB read path: data registered in setup, ready in access
    // ----------------------------------------------------------------
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            STAT_OFS:   next_rdata = {27'h0, ready, alarm_enable, cfg_user_sel,
                                      cfg_err, state == PST_FAULT};
            FAULT_OFS:  next_rdata = {29'h0, fault_rec};
            NVCFG_OFS:  next_rdata = {30'h0, nv_cfg};
            IRQST_OFS:  next_rdata = {29'h0, irq_st};
            IRQMSK_OFS: next_rdata = {29'h0, irq_mask};
            ERRQ_OFS:   next_rdata = {28'h0, cfg_err, fault_rec}; // R6
            default:    next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            prdata <= next_rdata;
        end
    end

    // Ready and error in the access phase only; unmapped address errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end
endmodule : pst_top
`default_nettype wire

// ---- sim/pst_top_monitor.sv ----
// Checker of lamp, sequence and bus timing at the self-test top ports
`timescale 1ns/1ps
`default_nettype none
module pst_top_monitor #(
    parameter longint unsigned SELFTEST_CYCLES = 64, // Total sequence time
    parameter longint unsigned FLASH_CYCLES    = 4   // Flash half period
) (
    input wire logic       pclk,                      // Clock
    input wire logic       presetn,                   // Reset, active low
    input wire logic       psel,                      // APB select
    input wire logic       penable,                   // APB enable
    input wire logic       pready,                    // APB ready
    input wire logic [2:0] fault_code,                // Test result pins
    input wire logic       exp_scan_store,            // Scan buffering pin
    input wire logic       talk_led,                  // Talk lamp
    input wire logic       listen_led,                // Listen lamp
    input wire logic       service_request_indicator, // Request lamp
    input wire logic       error_led,                 // Error lamp
    input wire logic       power_led,                 // Power lamp
    input wire logic       exp_scan_led,              // Expansion scan lamp
    input wire logic       exp_error_led,             // Expansion error lamp
    input wire logic       alarm_enable,              // Alarms on
    input wire logic       cfg_load,                  // Register load strobe
    input wire logic       chan_load,                 // Channel load strobe
    input wire logic       seq_load,                  // Sequencer strobe
    input wire logic       cpu_reset,                 // Processor reset
    input wire logic       ready                      // Ready
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Fault lamps other than error
    logic any_lamp;
    assign any_lamp = talk_led | listen_led | service_request_indicator;

    chk_power_on: assert property ($past(presetn) |-> power_led)
        else $error("power lamp off after reset");
    chk_step_order: assert property (cfg_load |-> ##2 chan_load ##1 seq_load ##1 cpu_reset)
        else $error("init strobes out of order");
    chk_alarm_step: assert property ($rose(alarm_enable) |-> ##[0:2] chan_load)
        else $error("alarm enable outside its step");
    chk_ready_late: assert property (cpu_reset |-> !ready ##[1:64] ready)
        else $error("ready not after processor reset");
    chk_lamps_idle: assert property (ready |-> !any_lamp)
        else $error("fault lamp lit while ready");
    chk_talk_code: assert property ($rose(talk_led) |-> fault_code inside {1, 5, 6, 7})
        else $error("talk lamp for wrong code");
    chk_listen_code: assert property ($rose(listen_led) |-> fault_code inside {4, 6, 7})
        else $error("listen lamp for wrong code");
    chk_srq_code: assert property ($rose(service_request_indicator)
        |-> fault_code inside {1, 3, 7})
        else $error("request lamp for wrong code");
    chk_flash_rate: assert property ($rose(error_led) && any_lamp
        |=> error_led [*3] ##1 !error_led)
        else $error("error lamp flash rate wrong");
    chk_scan_lamp: assert property ($rose(exp_scan_store) |-> ##[1:6] exp_scan_led)
        else $error("scan lamp did not follow pin");
    chk_exp_error: assert property ((ready && !error_led) [*2] |-> !exp_error_led)
        else $error("expansion error lamp without error");
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("bus answer late");

    cov_fault: cover property ($rose(talk_led));
    cov_ready: cover property ($rose(ready));
    cov_scan: cover property ($rose(exp_scan_led));
endmodule : pst_top_monitor
`default_nettype wire

// ---- sim/pst_host.sv ----
// Host model: issues the reset-power-on command as one pulse
`timescale 1ns/1ps
`default_nettype none
module pst_host (
    input  wire logic pclk,     // System clock
    input  wire logic restart,  // Bench request
    output logic      reset_cmd // Command pulse
);
    // Registered so the pulse changes just after an edge, never mid-cycle
    initial reset_cmd = 1'b0;
    always @(posedge pclk) begin
        reset_cmd <= restart;
    end
endmodule : pst_host
`default_nettype wire

// ---- sim/tb_powerup_selftest_led_status.sv ----
// Bench for the power-up self-test sequencer and its lamps
`timescale 1ns/1ps
`default_nettype none
module tb_powerup_selftest_led_status
    import pst_pkg::*;
();
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, restart = 1'b0, exp_scan_store = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [2:0]  fault_code = 3'h0;
    logic        pready, pslverr, reset_cmd, talk_led, listen_led, error_led;
    logic        service_request_indicator, power_led, exp_scan_led, exp_error_led;
    logic        cfg_user_sel, cfg_load, alarm_enable, chan_load, seq_load;
    logic        cpu_reset, ready, irq, e, hi, lo;
    int          failures = 0, n_compared = 0, seed = 23043;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;
    pst_top #(.SELFTEST_CYCLES(64), .FLASH_CYCLES(4)) dut (.*);
    pst_host u_host (.pclk(pclk), .restart(restart), .reset_cmd(reset_cmd));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("TB: compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic hang();
        failures++;
        end_of_test();
    endtask : hang
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // One transfer, then an idle cycle so strobes never clash
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) hang();
        @(posedge pclk);
    endtask : apb
    task automatic wait_ready();
        for (int n = 0; n < 200 && ready !== 1'b1; n++) @(posedge pclk);
        if (ready !== 1'b1) hang();
    endtask : wait_ready
    task automatic por(input logic [2:0] c);
        presetn    <= 1'b0;
        fault_code <= c;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (16) @(posedge pclk);
    endtask : por
    function automatic logic [31:0] obs();
        return {24'h0, ready, exp_scan_led, exp_error_led, error_led, talk_led,
                listen_led, service_request_indicator, power_led};
    endfunction : obs
    // Lamps for a fault code, flashing error bit left out
    function automatic logic [31:0] exp_lamps(input logic [2:0] c);
        logic [2:0] t [8];
        t = '{3'h0, 3'h5, 3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
        return {26'h0, c != 3'h0, 1'b0, t[c], 1'b1};
    endfunction : exp_lamps

    // Main sequence
    initial begin
        por(3'h0);
        wait_ready();
        cmp(obs(), 32'h81);
        apb(1'b0, STAT_OFS, 32'h0);
        cmp(r & 32'h11, 32'h10);
        apb(1'b1, IRQMSK_OFS, 32'h1);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, IRQST_OFS, 32'h1);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        $display("test power-up done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, NVCFG_OFS, 32'(i));
            if (i[0]) apb(1'b1, CTRL_OFS, 32'h1);
            else restart <= 1'b1;
            @(posedge pclk);
            restart <= 1'b0;
            repeat (3) @(posedge pclk);
            wait_ready();
            apb(1'b0, STAT_OFS, 32'h0);
            cmp({30'h0, r[3:2]}, {30'h0, i[NV_ALARMON], i[NV_USERCFG]});
            cmp({30'h0, alarm_enable, cfg_user_sel}, 32'(i));
            cmp(obs(), 32'h81);
        end
        $display("test restart done");
        apb(1'b1, CTRL_OFS, 32'h2);
        @(posedge pclk);
        cmp(obs(), 32'hb1);
        apb(1'b0, ERRQ_OFS, 32'h0);
        cmp(r, 32'h8);
        apb(1'b1, CTRL_OFS, 32'h4);
        @(posedge pclk);
        cmp(obs(), 32'h81);
        exp_scan_store <= 1'b1;
        repeat (6) @(posedge pclk);
        cmp(obs(), 32'hc1);
        exp_scan_store <= 1'b0;
        repeat (6) @(posedge pclk);
        cmp(obs(), 32'h81);
        apb(1'b0, {4'h1, 6'($random(seed)), 2'h0}, 32'h0);
        cmp({e, r[30:0]}, 32'h80000000);
        $display("test config and scan done");
        for (int c = 1; c < 8; c++) begin
            por(3'(c));
            cmp(obs() & 32'hef, exp_lamps(3'(c)));
            apb(1'b0, ERRQ_OFS, 32'h0);
            cmp(r, 32'(c));
            hi = 1'b0;
            lo = 1'b0;
            repeat (12) begin
                @(posedge pclk);
                hi |= error_led;
                lo |= !error_led;
            end
            cmp({30'h0, hi, lo}, 32'h3);
        end
        $display("test fault lamps done");
        end_of_test();
    end
endmodule : tb_powerup_selftest_led_status

bind pst_top pst_top_monitor #(
    .SELFTEST_CYCLES(SELFTEST_CYCLES),
    .FLASH_CYCLES(FLASH_CYCLES)
) u_mon (.*);
`default_nettype wire
